// ### dv/test_asq_config.sv
/*
 * Self-checking bench for asq_config: drives the register port and compares every result
 * with a behavioural model of classification, locks, stored sets, run entry and events.
 * Assumes the asq_pkg map, one 200 MHz clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module test_asq_config;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h00000000;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    logic [31:0] rdata_o;
    logic irq_o;
    asq_pkg::asq_vals_t live_o;
    logic [7:0] lock_o;
    logic run_o;
    int n_fail = 0;
    int checks_done = 0;
    logic [31:0] seed = 32'h1E0D0F9A;
    logic [15:0] m_live [8];
    logic [15:0] m_set [8][8];
    logic [7:0] m_ok, m_saved;
    logic [3:0] m_stat, m_en, m_sp;
    logic [2:0] m_first;
    logic m_setup, m_run, m_sok;
    // direct {0,2}: f6 implied, f3 and f5 fixed, f7 forced
    localparam logic [7:0] C_FIX = 8'h28;
    localparam logic [7:0] C_FRC = 8'h80;
    localparam logic [7:0] C_SEQ = 8'hED;

    always #2.5 clk_i = ~clk_i;

    asq_config i_asq_config (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .irq_o(irq_o),
        .live_o(live_o), .lock_o(lock_o), .run_o(run_o));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic logic good(input logic [15:0] v [8]);
        logic r;
        r = 1'b1;
        for (int p = 0; p < 8; p++)
            for (int f = 0; f < 8; f++)
                if (C_SEQ[p] && asq_pkg::ASQ_DEP[p][f] && v[p] > v[f]) r = 1'b0;
        return r;
    endfunction : good

    task automatic summarize();
        if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize

    task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : cmp

    task automatic chk();
        #1;
        for (int f = 0; f < 8; f++) cmp(32'(live_o[f]), 32'(m_live[f]));
        cmp(32'(lock_o), 32'(m_run ? C_SEQ : (m_setup ? C_FIX : 8'h00)));
        cmp(32'(run_o), 32'(m_run));
        cmp(32'(irq_o), 32'(|(m_stat & m_en)));
    endtask : chk

    task automatic mdl(input logic [7:0] a, input logic [31:0] d);
        logic v;
        if (a >= 8'h40 && a < 8'h60) begin
            if ((m_run ? C_SEQ[a[4:2]] : (m_setup && C_FIX[a[4:2]]))) m_stat[2] = 1'b1;
            else m_live[a[4:2]] = d[15:0];
        end else case (a)
            asq_pkg::ASQ_SETUP_MODE: if (!m_run) begin
                if (d[0] && !m_setup) m_sok = 1'b0;
                if (!d[0] && m_setup) begin
                    m_sok = m_ok[m_first] && ((m_ok & m_saved) == m_saved);
                    m_stat[3] = 1'b1;
                end
                m_setup = d[0];
            end
            asq_pkg::ASQ_RUN_MODE: if (!d[0]) m_run = 1'b0;
            else if (!m_setup && !m_run && m_sok) begin
                m_run = 1'b1;
                for (int f = 0; f < 8; f++) if (C_SEQ[f]) m_live[f] = m_set[m_first][f];
            end
            asq_pkg::ASQ_SET_PICK: m_sp = d[3:0];
            asq_pkg::ASQ_FIRST_SET: if (!m_run) m_first = d[2:0];
            asq_pkg::ASQ_IRQ_CLR: m_stat = m_stat & ~d[3:0];
            asq_pkg::ASQ_IRQ_EN: m_en = d[3:0];
            asq_pkg::ASQ_SET_CMD: if (!m_sp[3]) begin
                if (d[0] && !m_run) begin
                    begin
                        m_set[m_sp[2:0]] = m_live;
                        m_saved[m_sp[2:0]] = 1'b1;
                        m_stat[0] = 1'b1;
                        for (int s = 0; s < 8; s++) begin
                            v = good(m_set[s]);
                            for (int f = 0; f < 8; f++)
                                if (C_FIX[f] && m_set[s][f] !== m_live[f]) v = 1'b0;
                            m_ok[s] = m_saved[s] && v && (m_ok[s] || s == int'(m_sp));
                        end
                    end
                end else if (d[1] && m_ok[m_sp[2:0]]) begin
                    for (int f = 0; f < 8; f++) if (C_SEQ[f]) m_live[f] = m_set[m_sp[2:0]][f];
                    m_stat[1] = 1'b1;
                end
            end
            default: ;
        endcase
        if (m_run) m_live[7] = C_FRC[7] ? 16'h0000 : m_live[7];
    endtask : mdl

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
        mdl(a, d);
        chk();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1;
        cmp(rdata_o, exp);
    endtask : rd

    task automatic rd_ok();
        rd(asq_pkg::ASQ_SET_OK, {16'h0000, m_ok, 7'h00, m_ok[m_sp[2:0]]});
    endtask : rd_ok

    initial begin
        #(20000 * 5);
        n_fail++;
        summarize();
    end

    initial begin
        for (int f = 0; f < 8; f++) m_live[f] = asq_pkg::ASQ_LIVE_RST[f];
        {m_ok, m_saved, m_stat, m_en, m_sp, m_first} = '0;
        {m_setup, m_run, m_sok} = 3'b000;
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        chk();
        rd(8'hFC, 32'h00000000);
        wr(asq_pkg::ASQ_IRQ_EN, 32'h0000000F);
        wr(asq_pkg::ASQ_FEAT_PICK, 32'h0);
        wr(asq_pkg::ASQ_FEAT_ON, 32'h1);
        wr(asq_pkg::ASQ_FEAT_PICK, 32'h2);
        wr(asq_pkg::ASQ_FEAT_ON, 32'h1);
        wr(asq_pkg::ASQ_SETUP_MODE, 32'h1);
        rd(asq_pkg::ASQ_CLASS, 32'h80284005);
        wr(8'h4C, 32'h00000123);
        rd(asq_pkg::ASQ_IRQ_STAT, 32'(m_stat));
        wr(asq_pkg::ASQ_IRQ_CLR, 32'hF);
        wr(8'h58, 32'h00000100);
        wr(8'h5C, 32'h00000055);
        seed = xs(seed);
        wr(8'h44, seed);
        wr(asq_pkg::ASQ_SET_PICK, 32'h0);
        wr(asq_pkg::ASQ_SET_CMD, 32'h1);
        rd_ok();
        wr(asq_pkg::ASQ_SET_PICK, 32'h1);
        wr(8'h48, 32'h00000900);
        wr(asq_pkg::ASQ_SET_CMD, 32'h1);
        rd_ok();
        wr(asq_pkg::ASQ_SET_CMD, 32'h2);
        wr(8'h48, 32'h00000300);
        wr(asq_pkg::ASQ_SET_PICK, 32'h0);
        wr(asq_pkg::ASQ_SET_CMD, 32'h2);
        wr(asq_pkg::ASQ_SET_PICK, 32'h8);
        wr(asq_pkg::ASQ_SET_CMD, 32'h1);
        wr(asq_pkg::ASQ_SET_CMD, 32'h2);
        wr(asq_pkg::ASQ_SETUP_MODE, 32'h0);
        rd(asq_pkg::ASQ_SETUP_OK, 32'(m_sok));
        wr(8'h4C, 32'h00000300);
        wr(asq_pkg::ASQ_SETUP_MODE, 32'h1);
        wr(asq_pkg::ASQ_SET_PICK, 32'h1);
        wr(8'h48, 32'h00000200);
        wr(8'h40, 32'h00000080);
        wr(asq_pkg::ASQ_SET_CMD, 32'h1);
        rd_ok();
        wr(8'h40, 32'h00000100);
        wr(asq_pkg::ASQ_SET_PICK, 32'h0);
        wr(asq_pkg::ASQ_SET_CMD, 32'h3);
        rd_ok();
        wr(asq_pkg::ASQ_FIRST_SET, 32'h1);
        wr(asq_pkg::ASQ_RUN_MODE, 32'h1);
        wr(asq_pkg::ASQ_SETUP_MODE, 32'h0);
        rd(asq_pkg::ASQ_SETUP_OK, 32'(m_sok));
        wr(asq_pkg::ASQ_RUN_MODE, 32'h1);
        wr(asq_pkg::ASQ_IRQ_CLR, 32'hF);
        wr(asq_pkg::ASQ_IRQ_EN, 32'hB);
        wr(8'h40, 32'h00000005);
        wr(8'h58, 32'h00000007);
        wr(asq_pkg::ASQ_SET_CMD, 32'h1);
        wr(asq_pkg::ASQ_FIRST_SET, 32'h0);
        wr(asq_pkg::ASQ_SET_CMD, 32'h2);
        rd(asq_pkg::ASQ_IRQ_STAT, 32'(m_stat));
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            wr(seed[2] ? 8'h50 : 8'h44, seed);
        end
        wr(asq_pkg::ASQ_FEAT_ON, 32'h0);
        rd(asq_pkg::ASQ_FEAT_ON, 32'h00000001);
        rd(asq_pkg::ASQ_FEAT_PICK, 32'h00000002);
        rd(asq_pkg::ASQ_FIRST_SET, 32'(m_first));
        rd(asq_pkg::ASQ_SET_PICK, 32'(m_sp));
        rd(asq_pkg::ASQ_RUN_MODE, 32'(m_run));
        rd(asq_pkg::ASQ_SETUP_MODE, 32'(m_setup));
        rd(asq_pkg::ASQ_IRQ_EN, 32'(m_en));
        wr(asq_pkg::ASQ_RUN_MODE, 32'h0);
        summarize();
    end
endmodule : test_asq_config

// ### verilog/asq_config.sv
/*
 * Configuration side of the acquisition set sequencer: feature classification and locks,
 * eight stored parameter sets with validity checks, store, restore and run entry.
 * Assumes a register master on the same clock that issues one-cycle strobes.
 */
`timescale 1ns/1ps
module asq_config (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // register port
    input wire logic [asq_pkg::ASQ_AW-1:0] addr_i,
    input wire logic [asq_pkg::ASQ_DW-1:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [asq_pkg::ASQ_DW-1:0] rdata_o,
    // interrupt
    output logic irq_o,
    // live configuration and locks
    output asq_pkg::asq_vals_t live_o,
    output logic [asq_pkg::ASQ_NFEAT-1:0] lock_o,
    output logic run_o
);
    localparam int NF = asq_pkg::ASQ_NFEAT;

    logic [2:0] feat_pick;
    logic [NF-1:0] feat_on;
    logic setup_mode;
    logic run_mode;
    logic [3:0] set_index_pick;
    logic [2:0] first_set_index;
    logic seq_setup_ok_flag;
    logic [NF-1:0] direct_m, implied_m, fixed_m, forced_m;
    logic [asq_pkg::ASQ_NSET-1:0] set_ok_flag;
    logic [asq_pkg::ASQ_NSET-1:0] saved_m;
    asq_pkg::asq_vals_t set_mem [asq_pkg::ASQ_NSET];
    asq_pkg::asq_vals_t live;
    logic [asq_pkg::ASQ_NEV-1:0] irq_stat;
    logic [asq_pkg::ASQ_NEV-1:0] irq_en;

    // register port decode; feat_hit is shared by the read and write paths, reg_hit serves the write path only
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        reg_hit = (a == off);
    endfunction : reg_hit

    function automatic logic feat_hit(input logic [7:0] a);
        feat_hit = (a[7:5] == asq_pkg::ASQ_FEAT_PAGE) && (a[1:0] == 2'h0);
    endfunction : feat_hit

    // every sequenced feature must stay within each of its preconditions
    function automatic logic set_check(input asq_pkg::asq_vals_t v, input logic [NF-1:0] m);
        logic ok;
        ok = 1'b1;
        for (int f = 0; f < NF; f++) begin
            for (int p = 0; p < NF; p++) begin
                if (m[f] && asq_pkg::ASQ_DEP[f][p] && (v[f] > v[p])) begin
                    ok = 1'b0;
                end
            end
        end
        set_check = ok;
    endfunction : set_check

    // fixed values of a stored set must match the current ones
    function automatic logic fixed_same(input asq_pkg::asq_vals_t a, input asq_pkg::asq_vals_t b,
                                        input logic [NF-1:0] m);
        logic same;
        same = 1'b1;
        for (int f = 0; f < NF; f++) begin
            if (m[f] && (a[f] != b[f])) begin
                same = 1'b0;
            end
        end
        fixed_same = same;
    endfunction : fixed_same

    // classification from the enabled direct features
    logic [NF-1:0] next_implied, next_fixed, next_forced;
    always_comb begin
        logic [NF-1:0] seqd;
        seqd = '0;
        next_implied = '0;
        next_fixed = '0;
        next_forced = '0;
        for (int f = 0; f < NF; f++) begin
            if (!feat_on[f] && |(asq_pkg::ASQ_DEP[f] & feat_on)) begin
                next_implied[f] = 1'b1;
            end
        end
        seqd = feat_on | next_implied;
        for (int f = 0; f < NF; f++) begin
            if (seqd[f]) begin
                next_fixed = next_fixed | asq_pkg::ASQ_DEP[f];
            end
        end
        // preconditions of fixed features are fixed as well
        for (int f = 0; f < NF; f++) begin
            if (next_fixed[f]) begin
                next_fixed = next_fixed | asq_pkg::ASQ_DEP[f];
            end
        end
        next_fixed = next_fixed & ~seqd;
        for (int f = 0; f < NF; f++) begin
            if (|(asq_pkg::ASQ_AUTO_CTRL[f] & (seqd | next_fixed))) begin
                next_forced[f] = 1'b1;
            end
        end
    end

    logic [NF-1:0] seq_m;
    logic [NF-1:0] lock_m;
    assign seq_m = direct_m | implied_m | fixed_m | forced_m;
    // non-sequenced features are never in the lock mask
    assign lock_m = run_mode ? seq_m : (setup_mode ? fixed_m : '0);

    // write strobes
    logic wr_setup, wr_run, set_in_range, do_store, do_restore, run_go, wr_feat, feat_refused;
    logic [2:0] set_idx, feat_idx;
    assign set_idx = set_index_pick[2:0];
    assign set_in_range = (set_index_pick[3] == 1'b0);
    assign wr_setup = we_i && reg_hit(addr_i, asq_pkg::ASQ_SETUP_MODE);
    assign wr_run = we_i && reg_hit(addr_i, asq_pkg::ASQ_RUN_MODE);
    assign do_store = we_i && reg_hit(addr_i, asq_pkg::ASQ_SET_CMD) &&
                      wdata_i[asq_pkg::ASQ_CMD_STORE] && set_in_range && !run_mode;
    // only a set that passed its check can be restored
    assign do_restore = we_i && reg_hit(addr_i, asq_pkg::ASQ_SET_CMD) &&
                        wdata_i[asq_pkg::ASQ_CMD_RESTORE] && !do_store && set_in_range &&
                        set_ok_flag[set_idx];
    // run may start only with a checked configuration, outside setup
    assign run_go = wr_run && wdata_i[0] && !run_mode && !setup_mode && seq_setup_ok_flag;
    assign feat_idx = addr_i[4:2];
    assign wr_feat = we_i && feat_hit(addr_i);
    assign feat_refused = wr_feat && lock_m[feat_idx];

    // feature selection and enable
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            feat_pick <= 3'h0;
            feat_on <= '0;
        end else if (we_i && reg_hit(addr_i, asq_pkg::ASQ_FEAT_PICK)) begin
            feat_pick <= wdata_i[2:0];
        end else if (we_i && reg_hit(addr_i, asq_pkg::ASQ_FEAT_ON) && !run_mode) begin
            feat_on[feat_pick] <= wdata_i[0];
        end
    end

    // setup mode, classification and whole-configuration check
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            setup_mode <= 1'b0;
            seq_setup_ok_flag <= 1'b0;
            direct_m <= '0;
            implied_m <= '0;
            fixed_m <= '0;
            forced_m <= '0;
        end else if (wr_setup && !run_mode) begin
            setup_mode <= wdata_i[0];
            if (wdata_i[0] && !setup_mode) begin
                // the choice of direct features is taken as it stands now
                direct_m <= feat_on;
                implied_m <= next_implied;
                fixed_m <= next_fixed;
                forced_m <= next_forced;
                seq_setup_ok_flag <= 1'b0;
            end else if (!wdata_i[0] && setup_mode) begin
                seq_setup_ok_flag <= set_ok_flag[first_set_index] &&
                                     ((saved_m & ~set_ok_flag) == '0);
            end
        end
    end

    // run mode and starting set
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            run_mode <= 1'b0;
            first_set_index <= 3'h0;
        end else begin
            if (run_go) begin
                run_mode <= 1'b1;
            end else if (wr_run && !wdata_i[0]) begin
                run_mode <= 1'b0;
            end
            if (we_i && reg_hit(addr_i, asq_pkg::ASQ_FIRST_SET) && !run_mode) begin
                first_set_index <= wdata_i[2:0];
            end
        end
    end

    // set selector
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            set_index_pick <= 4'h0;
        end else if (we_i && reg_hit(addr_i, asq_pkg::ASQ_SET_PICK)) begin
            set_index_pick <= wdata_i[3:0];
        end
    end

    // stored sets and their validity
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            set_ok_flag <= '0;
            saved_m <= '0;
        end else if (do_store) begin
            // the whole live snapshot goes in, dependents included
            set_mem[set_idx] <= live;
            saved_m[set_idx] <= 1'b1;
            set_ok_flag[set_idx] <= set_check(live, seq_m);
            for (int k = 0; k < asq_pkg::ASQ_NSET; k++) begin
                if (k != int'(set_idx)) begin
                    set_ok_flag[k] <= set_ok_flag[k] && set_check(set_mem[k], seq_m) &&
                                      fixed_same(set_mem[k], live, fixed_m);
                end
            end
        end
    end

    // live configuration
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            live <= asq_pkg::ASQ_LIVE_RST;
        end else begin
            for (int f = 0; f < NF; f++) begin
                if (run_go && seq_m[f]) begin
                    live[f] <= set_mem[first_set_index][f];
                end else if (do_restore && seq_m[f]) begin
                    live[f] <= set_mem[set_idx][f];
                end else if (wr_feat && !lock_m[feat_idx] && (feat_idx == 3'(f))) begin
                    live[f] <= wdata_i[asq_pkg::ASQ_VW-1:0];
                end
                // forced features already read off in the cycle that run starts
                if ((run_mode || run_go) && forced_m[f]) begin
                    live[f] <= asq_pkg::ASQ_OFF_VAL;
                end
            end
        end
    end

    // interrupt status, enable and clear; an event beats a clear in the same cycle
    logic [asq_pkg::ASQ_NEV-1:0] ev;
    always_comb begin
        ev = '0;
        ev[asq_pkg::ASQ_EV_STORE] = do_store;
        ev[asq_pkg::ASQ_EV_RESTORE] = do_restore;
        ev[asq_pkg::ASQ_EV_REFUSED] = feat_refused;
        ev[asq_pkg::ASQ_EV_CHECK] = wr_setup && !wdata_i[0] && setup_mode && !run_mode;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            irq_stat <= '0;
            irq_en <= '0;
        end else begin
            if (we_i && reg_hit(addr_i, asq_pkg::ASQ_IRQ_CLR)) begin
                irq_stat <= (irq_stat & ~wdata_i[asq_pkg::ASQ_NEV-1:0]) | ev;
            end else begin
                irq_stat <= irq_stat | ev;
            end
            if (we_i && reg_hit(addr_i, asq_pkg::ASQ_IRQ_EN)) begin
                irq_en <= wdata_i[asq_pkg::ASQ_NEV-1:0];
            end
        end
    end

    // read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rdata_o <= '0;
        end else if (re_i) begin
            rdata_o <= '0;
            if (feat_hit(addr_i)) begin
                rdata_o <= {16'h0000, live[addr_i[4:2]]};
            end else begin
                unique case (addr_i)
                    asq_pkg::ASQ_FEAT_PICK: rdata_o <= {29'h0, feat_pick};
                    asq_pkg::ASQ_FEAT_ON: rdata_o <= {31'h0, feat_on[feat_pick]};
                    asq_pkg::ASQ_SETUP_MODE: rdata_o <= {31'h0, setup_mode};
                    asq_pkg::ASQ_RUN_MODE: rdata_o <= {31'h0, run_mode};
                    asq_pkg::ASQ_SET_PICK: rdata_o <= {28'h0, set_index_pick};
                    asq_pkg::ASQ_SET_OK: rdata_o <= {16'h0, set_ok_flag, 7'h0,
                                                      set_in_range && set_ok_flag[set_idx]};
                    asq_pkg::ASQ_FIRST_SET: rdata_o <= {29'h0, first_set_index};
                    asq_pkg::ASQ_SETUP_OK: rdata_o <= {31'h0, seq_setup_ok_flag};
                    asq_pkg::ASQ_CLASS: rdata_o <= {forced_m, fixed_m, implied_m, direct_m};
                    asq_pkg::ASQ_IRQ_STAT: rdata_o <= {28'h0, irq_stat};
                    asq_pkg::ASQ_IRQ_EN: rdata_o <= {28'h0, irq_en};
                    default: rdata_o <= '0;
                endcase
            end
        end
    end

    assign irq_o = |(irq_stat & irq_en);
    assign live_o = live;
    assign lock_o = lock_m;
    assign run_o = run_mode;

    // checks
    logic forced_not_off;
    always_comb begin
        forced_not_off = 1'b0;
        for (int f = 0; f < NF; f++) begin
            if (forced_m[f] && (live[f] != asq_pkg::ASQ_OFF_VAL)) begin
                forced_not_off = 1'b1;
            end
        end
    end

    locked_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        feat_refused |=> live == $past(live) && irq_stat[asq_pkg::ASQ_EV_REFUSED])
        else $error("locked feature write changed the live configuration");
    fixed_lock_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (setup_mode || run_mode) |-> (lock_m & fixed_m) == fixed_m)
        else $error("fixed feature unlocked during setup or run");
    implied_lock_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (setup_mode && !run_mode) |-> (lock_m & implied_m) == '0)
        else $error("implied feature locked during setup");
    forced_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        run_mode |-> !forced_not_off)
        else $error("forced feature not held off while running");
    class_entry_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        wr_setup && wdata_i[0] && !setup_mode && !run_mode |=>
        setup_mode && (lock_m == fixed_m) && ((fixed_m & (direct_m | implied_m)) == '0))
        else $error("setup entry did not lock exactly the fixed features");
    store_copy_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        do_store |=> set_mem[$past(set_idx)] == $past(live) && saved_m[$past(set_idx)])
        else $error("store did not copy the live configuration");
    range_guard_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !set_in_range |-> !do_store && !do_restore)
        else $error("command acted on an out-of-range set");
    run_entry_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        run_go |=> run_mode && (lock_m == seq_m) && !forced_not_off)
        else $error("run entry did not lock the sequenced features");
    first_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        run_go |=> fixed_same(live, set_mem[$past(first_set_index)], seq_m & ~forced_m))
        else $error("run entry did not load the starting set");
    setup_check_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        wr_setup && !wdata_i[0] && setup_mode && !run_mode |=>
        seq_setup_ok_flag == ($past(set_ok_flag[first_set_index]) &&
                              (($past(saved_m) & ~$past(set_ok_flag)) == '0)))
        else $error("configuration check result wrong after leaving setup");
    restore_valid_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        do_restore && !run_mode |=> fixed_same(live, set_mem[$past(set_idx)], seq_m) &&
        irq_stat[asq_pkg::ASQ_EV_RESTORE])
        else $error("restore did not load the selected set");
endmodule : asq_config

// ### verilog/asq_pkg.sv
/*
 * Constants, feature dependency tables and register map of the acquisition set sequencer
 * configuration block.
 * Assumes one 200 MHz core clock, a synchronous active-low reset and a plain register port.
 */
// Behaviour
// - eight independently saved parameter sets
// - enabled direct features apply to all sets
// - setup entry classifies features, locks fixed ones
// - fixed features locked in setup and run
// - implied writable in setup, locked in run
// - forced features held off while running
// - store copies live features into picked set
// - set holds direct and dependent settings
// - store checks set, reports its validity
// - store re-evaluates other sets, may invalidate
// - restore loads valid set in any mode
// - non-sequenced features never changed or locked
// - run entry locks sequenced, loads first set
// - first set index names starting set
// - leaving setup checks whole configuration validity
package asq_pkg;
    localparam int ASQ_NFEAT = 8;
    localparam int ASQ_NSET = 8;
    localparam int ASQ_VW = 16;
    localparam int ASQ_AW = 8;
    localparam int ASQ_DW = 32;
    localparam int ASQ_NEV = 4;

    typedef logic [ASQ_NFEAT-1:0][ASQ_VW-1:0] asq_vals_t;
    typedef logic [ASQ_NFEAT-1:0][ASQ_NFEAT-1:0] asq_mat_t;

    // register byte offsets
    localparam logic [7:0] ASQ_FEAT_PICK = 8'h00;
    localparam logic [7:0] ASQ_FEAT_ON = 8'h04;
    localparam logic [7:0] ASQ_SETUP_MODE = 8'h08;
    localparam logic [7:0] ASQ_RUN_MODE = 8'h0C;
    localparam logic [7:0] ASQ_SET_PICK = 8'h10;
    localparam logic [7:0] ASQ_SET_CMD = 8'h14;
    localparam logic [7:0] ASQ_SET_OK = 8'h18;
    localparam logic [7:0] ASQ_FIRST_SET = 8'h1C;
    localparam logic [7:0] ASQ_SETUP_OK = 8'h20;
    localparam logic [7:0] ASQ_CLASS = 8'h24;
    localparam logic [7:0] ASQ_IRQ_STAT = 8'h28;
    localparam logic [7:0] ASQ_IRQ_CLR = 8'h2C;
    localparam logic [7:0] ASQ_IRQ_EN = 8'h30;
    // live feature values at 0x40 + 4*index
    localparam logic [2:0] ASQ_FEAT_PAGE = 3'h2;

    // command bits of the set command register
    localparam int ASQ_CMD_STORE = 0;
    localparam int ASQ_CMD_RESTORE = 1;

    // event bits of the status, clear and enable registers
    localparam int ASQ_EV_STORE = 0;
    localparam int ASQ_EV_RESTORE = 1;
    localparam int ASQ_EV_REFUSED = 2;
    localparam int ASQ_EV_CHECK = 3;

    // bit f of row p: feature p must not exceed feature f
    localparam asq_mat_t ASQ_DEP = {8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h08, 8'h10, 8'h20};
    // bit f of row a: automatic feature a drives feature f
    localparam asq_mat_t ASQ_AUTO_CTRL = {8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam asq_vals_t ASQ_LIVE_RST = {16'h0000, 16'h0000, 16'h1000, 16'h00FF,
                                          16'h0800, 16'h0400, 16'h0000, 16'h0100};
    // manual (off) setting of an automatic feature
    localparam logic [ASQ_VW-1:0] ASQ_OFF_VAL = 16'h0000;
endpackage : asq_pkg
